// >>> clkdist_defs.svh
/*
 * offsets, reset values and limits of the clock distribution block.
 * assumes byte addresses on the register port; included by bare name.
 */
`ifndef CLKDIST_DEFS_SVH
`define CLKDIST_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define PAIR_CFG_BASE  8'h00
`define PAIR_SDLY_BASE 8'h20
`define SYSREF_CFG     8'h40
`define DYN_DLY        8'h44
`define MISC_CFG       8'h48
`define STATUS         8'h4C
// ----------------------------------------
// limits and reset values
// ----------------------------------------
`define DCLK_DIV_MIN   10'h001
`define DCLK_DIV_RST   10'h004
`define SREF_DIV_MIN   13'h0008
`define SREF_DIV_RST   13'h0080
`define DDLY_MIN       10'h008
`define LSDLY_MIN      4'h1
`define LSDLY_MAX      4'hA
`define DCLK_SIX       3'h3
`define DCLK_EIGHT     3'h4
`endif

// >>> clkdist_pkg.sv
/*
 * types shared by the clock distribution block.
 * assumes clkdist_defs.svh for all numeric constants.
 */
package clkdist_pkg;
    typedef enum logic [1:0] {fmt_off, fmt_cml, fmt_lvds, fmt_pecl} fmt_t;
    typedef struct packed {
        logic       sync_dis;
        logic       ddly_half;
        logic [9:0] ddly;
        fmt_t       fmt_odd;
        fmt_t       fmt_even;
        logic       sysref_on;
        logic       swap;
        logic       bypass;
        logic       dcc;
        logic [9:0] div;
    } pair_cfg_t;
    typedef struct packed {
        logic       half;
        logic [3:0] dly;
    } pair_sdly_t;
    typedef enum logic [1:0] {sync_idle, sync_hold, sync_delay} sync_st_t;
endpackage : clkdist_pkg

// >>> clock_distribution_divider_delay.sv
/*
 * clock distribution stage: seven paired device clock dividers, shared sysref
 * divider, fixed and dynamic digital delay, sync alignment, output, feedback
 * and status selection. assumes mclk stands for the distribution path clock and
 * a register master that never overlaps strobes.
 */
`timescale 1ns/1ps
`include "clkdist_defs.svh"
module clock_distribution_divider_delay #(
    parameter int PAIRS = 7
) (
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                nrst,
    // register port
    input  wire logic [7:0]          addr,
    input  wire logic [31:0]         wdata,
    input  wire logic                wr,
    input  wire logic                rd,
    output logic      [31:0]         rdata,
    // sync and reference side
    input  wire logic                sync_path,
    input  wire logic                second_loop_oscillator_input,
    input  wire logic                first_loop_reference_input,
    input  wire logic                external_feedback_input,
    input  wire logic [3:0]          status_src,
    // clock outputs, even at 2p, odd at 2p+1
    output logic [2*PAIRS-1:0]       clock_output,
    output logic [2*PAIRS-1:0]       clock_output_half,
    output logic                     buffered_oscillator_output,
    // zero delay phase detector
    output logic                     pd_reference,
    output logic                     pd_feedback,
    // status pins
    output logic                     lock_status_pin_one,
    output logic                     lock_status_pin_two,
    input  wire logic                reference_select_pin_one_in,
    output logic                     reference_select_pin_one_out,
    output logic                     reference_select_pin_one_oe_n,
    output logic                     reference_select
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [9:0] clamp10(input logic [9:0] v, input logic [9:0] lo);
        clamp10 = (v < lo) ? lo : v;
    endfunction : clamp10

    function automatic logic fmt_ok(input logic bypass, input clkdist_pkg::fmt_t f);
        fmt_ok = bypass ? (f == clkdist_pkg::fmt_cml)
                        : (f != clkdist_pkg::fmt_cml && f != clkdist_pkg::fmt_off);
    endfunction : fmt_ok

    // ----------------------------------------
    // registers
    // ----------------------------------------
    clkdist_pkg::pair_cfg_t  pcfg  [PAIRS];
    clkdist_pkg::pair_sdly_t psdly [PAIRS];
    logic [9:0]  act_ddly [PAIRS];
    logic [12:0] sref_div;
    logic [12:0] sref_ddly;
    logic        sref_sync_dis;
    logic [1:0]  osc_sel;
    logic [1:0]  fb_sel;
    logic        nested;
    logic [2:0]  st1_sel;
    logic [2:0]  st2_sel;
    logic [7:0]  dyn_left;
    logic        dyn_half;
    logic [12:0] dyn_gap;
    logic [9:0]  dyn_pause;
    logic [PAIRS-1:0] half_ph;
    logic [PAIRS-1:0] bad_fmt;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            for (int p = 0; p < PAIRS; p++) begin
                pcfg[p]  <= '{div: `DCLK_DIV_RST, ddly: `DDLY_MIN,
                              fmt_even: clkdist_pkg::fmt_lvds,
                              fmt_odd: clkdist_pkg::fmt_lvds, default: '0};
                psdly[p] <= '{dly: `LSDLY_MIN, half: 1'b0};
            end
            sref_div      <= `SREF_DIV_RST;
            sref_ddly     <= `SREF_DIV_MIN;
            sref_sync_dis <= 1'b0;
            osc_sel       <= 2'h0;
            fb_sel        <= 2'h0;
            nested        <= 1'b0;
            st1_sel       <= 3'h0;
            st2_sel       <= 3'h0;
        end else if (wr) begin
            for (int p = 0; p < PAIRS; p++) begin
                if (addr == `PAIR_CFG_BASE + 8'(4 * p))
                    pcfg[p] <= clkdist_pkg::pair_cfg_t'(wdata[29:0]);
                if (addr == `PAIR_SDLY_BASE + 8'(4 * p))
                    psdly[p] <= clkdist_pkg::pair_sdly_t'(wdata[4:0]);
            end
            if (addr == `SYSREF_CFG) begin
                sref_div      <= wdata[12:0];
                sref_ddly     <= wdata[25:13];
                sref_sync_dis <= wdata[26];
            end
            if (addr == `MISC_CFG) begin
                osc_sel <= wdata[1:0];
                fb_sel  <= wdata[3:2];
                nested  <= wdata[4];
                st1_sel <= wdata[7:5];
                st2_sel <= wdata[10:8];
            end
        end
    end

    // read data in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdata <= 32'h0;
        end else begin
            rdata <= 32'h0;
            if (rd) begin
                for (int p = 0; p < PAIRS; p++) begin
                    if (addr == `PAIR_CFG_BASE + 8'(4 * p))
                        rdata <= {2'h0, pcfg[p]};
                    if (addr == `PAIR_SDLY_BASE + 8'(4 * p))
                        rdata <= {27'h0, psdly[p]};
                end
                if (addr == `SYSREF_CFG)
                    rdata <= {5'h0, sref_sync_dis, sref_ddly, sref_div};
                if (addr == `DYN_DLY)
                    rdata <= {23'h0, dyn_half, dyn_left};
                if (addr == `MISC_CFG)
                    rdata <= {21'h0, st2_sel, st1_sel, nested, fb_sel, osc_sel};
                if (addr == `STATUS)
                    rdata <= {24'h0, sync_path, bad_fmt};
            end
        end
    end

    // ----------------------------------------
    // sync sequencing
    // ----------------------------------------
    clkdist_pkg::sync_st_t sync_st;
    logic [12:0] sync_cnt;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sync_st  <= clkdist_pkg::sync_idle;
            sync_cnt <= 13'h0;
        end else begin
            case (sync_st)
                clkdist_pkg::sync_idle: begin
                    if (sync_path)
                        sync_st <= clkdist_pkg::sync_hold;
                end
                clkdist_pkg::sync_hold: begin
                    if (!sync_path) begin
                        sync_st  <= clkdist_pkg::sync_delay;
                        sync_cnt <= 13'h0;
                    end
                end
                clkdist_pkg::sync_delay: begin
                    sync_cnt <= sync_cnt + 13'h1;
                    if (sync_cnt >= sref_ddly) begin
                        sync_st <= clkdist_pkg::sync_idle;
                    end
                end
                default: sync_st <= clkdist_pkg::sync_idle;
            endcase
        end
    end

    // ----------------------------------------
    // dynamic digital delay
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            dyn_left  <= 8'h0;
            dyn_half  <= 1'b0;
            dyn_gap   <= 13'h0;
            dyn_pause <= 10'h0;
            half_ph   <= '0;
        end else if (wr && addr == `DYN_DLY) begin
            // up to 255 steps per write
            dyn_left <= wdata[7:0];
            dyn_half <= wdata[8];
            dyn_gap  <= 13'h0;
            // half step on every pair that follows sync
            if (wdata[8]) begin
                for (int p = 0; p < PAIRS; p++)
                    half_ph[p] <= half_ph[p] ^ ~pcfg[p].sync_dis;
            end
        end else begin
            if (dyn_pause != 10'h0)
                dyn_pause <= dyn_pause - 10'h1;
            if (dyn_left != 8'h0 && dyn_pause == 10'h0) begin
                // sysref delay value spaces the steps
                if (dyn_gap >= sref_ddly) begin
                    dyn_gap   <= 13'h0;
                    dyn_left  <= dyn_left - 8'h1;
                    dyn_pause <= clamp10(pcfg[0].div, `DCLK_DIV_MIN);
                end else begin
                    dyn_gap <= dyn_gap + 13'h1;
                end
            end
        end
    end

    // ----------------------------------------
    // device clock dividers
    // ----------------------------------------
    logic [9:0]       dcnt [PAIRS];
    logic [9:0]       dwait [PAIRS];
    logic [PAIRS-1:0] dclk;
    logic [PAIRS-1:0] hold;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            for (int p = 0; p < PAIRS; p++) begin
                dcnt[p]     <= 10'h0;
                dwait[p]    <= 10'h0;
                act_ddly[p] <= `DDLY_MIN;
            end
            dclk <= '0;
            hold <= '0;
        end else begin
            for (int p = 0; p < PAIRS; p++) begin
                if (sync_path && !pcfg[p].sync_dis) begin
                    // held in reset while sync high
                    hold[p]     <= 1'b1;
                    dcnt[p]     <= 10'h0;
                    dwait[p]    <= 10'h0;
                    dclk[p]     <= 1'b0;
                    act_ddly[p] <= clamp10(pcfg[p].ddly, `DDLY_MIN);
                end else if (hold[p]) begin
                    if (dwait[p] + 10'h1 >= act_ddly[p]) begin
                        hold[p]  <= 1'b0;
                        dwait[p] <= 10'h0;
                    end else begin
                        dwait[p] <= dwait[p] + 10'h1;
                    end
                end else if (dyn_pause != 10'h0 && !pcfg[p].sync_dis) begin
                    dclk[p] <= dclk[p];
                end else begin
                    if (dcnt[p] + 10'h1 >= clamp10(pcfg[p].div, `DCLK_DIV_MIN))
                        dcnt[p] <= 10'h0;
                    else
                        dcnt[p] <= dcnt[p] + 10'h1;
                    if (pcfg[p].div <= `DCLK_DIV_MIN)
                        dclk[p] <= 1'b1;
                    else if (pcfg[p].dcc)
                        dclk[p] <= dcnt[p] < (pcfg[p].div >> 1);
                    else
                        dclk[p] <= dcnt[p] == 10'h0;
                end
            end
        end
    end

    // ----------------------------------------
    // sysref divider and local delay
    // ----------------------------------------
    logic [12:0] scnt;
    logic        sref;
    logic [10:0] sshift [PAIRS];
    logic [12:0] sdiv_eff;

    assign sdiv_eff = (sref_div < `SREF_DIV_MIN) ? `SREF_DIV_MIN : sref_div;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            scnt <= 13'h0;
            sref <= 1'b0;
        end else if ((sync_path && !sref_sync_dis) || sync_st != clkdist_pkg::sync_idle) begin
            scnt <= 13'h0;
            sref <= 1'b0;
        end else begin
            // 8 to 8191, plain half split
            scnt <= (scnt + 13'h1 >= sdiv_eff) ? 13'h0 : scnt + 13'h1;
            sref <= scnt < (sdiv_eff >> 1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            for (int p = 0; p < PAIRS; p++)
                sshift[p] <= 11'h0;
        end else begin
            for (int p = 0; p < PAIRS; p++)
                sshift[p] <= {sshift[p][9:0], sref};
        end
    end

    // ----------------------------------------
    // output routing and format checks
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            clock_output      <= '0;
            clock_output_half <= '0;
            bad_fmt           <= '0;
        end else begin
            for (int p = 0; p < PAIRS; p++) begin
                logic [3:0] tap;
                logic       s;
                logic       e;
                tap = (psdly[p].dly > `LSDLY_MAX) ? `LSDLY_MAX :
                      (psdly[p].dly < `LSDLY_MIN) ? `LSDLY_MIN : psdly[p].dly;
                s   = sshift[p][tap];
                e   = pcfg[p].bypass ? 1'b1 : dclk[p];
                bad_fmt[p] <= !fmt_ok(pcfg[p].bypass, pcfg[p].fmt_even);
                if (pcfg[p].sysref_on && pcfg[p].swap) begin
                    clock_output[2*p]   <= s & fmt_ok(1'b0, pcfg[p].fmt_even);
                    clock_output[2*p+1] <= dclk[p];
                end else if (pcfg[p].sysref_on) begin
                    clock_output[2*p]   <= e & fmt_ok(pcfg[p].bypass, pcfg[p].fmt_even);
                    clock_output[2*p+1] <= s;
                end else begin
                    clock_output[2*p]   <= e & fmt_ok(pcfg[p].bypass, pcfg[p].fmt_even);
                    clock_output[2*p+1] <= dclk[p];
                end
                clock_output_half[2*p]   <= pcfg[p].sysref_on && pcfg[p].swap ?
                                            psdly[p].half : pcfg[p].ddly_half ^ half_ph[p];
                clock_output_half[2*p+1] <= pcfg[p].sysref_on && !pcfg[p].swap ?
                                            psdly[p].half : pcfg[p].ddly_half ^ half_ph[p];
            end
        end
    end

    // ----------------------------------------
    // oscillator output, feedback, status
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            buffered_oscillator_output    <= 1'b0;
            pd_reference                  <= 1'b0;
            pd_feedback                   <= 1'b0;
            lock_status_pin_one           <= 1'b0;
            lock_status_pin_two           <= 1'b0;
            reference_select_pin_one_out  <= 1'b0;
            reference_select_pin_one_oe_n <= 1'b1;
            reference_select              <= 1'b0;
        end else begin
            case (osc_sel)
                2'h0:    buffered_oscillator_output <= second_loop_oscillator_input;
                2'h1:    buffered_oscillator_output <= dclk[`DCLK_SIX];
                2'h2:    buffered_oscillator_output <= dclk[`DCLK_EIGHT];
                default: buffered_oscillator_output <= sref;
            endcase
            case (fb_sel)
                2'h0:    pd_feedback <= dclk[`DCLK_SIX];
                2'h1:    pd_feedback <= dclk[`DCLK_EIGHT];
                2'h2:    pd_feedback <= sref;
                default: pd_feedback <= external_feedback_input;
            endcase
            pd_reference <= nested ? first_loop_reference_input
                                   : second_loop_oscillator_input;
            lock_status_pin_one <= (st1_sel < 3'h4) ? status_src[st1_sel[1:0]]
                                 : (st1_sel == 3'h4) ? sref : 1'b0;
            lock_status_pin_two <= (st2_sel < 3'h4) ? status_src[st2_sel[1:0]]
                                 : (st2_sel == 3'h4) ? dclk[0] : 1'b0;
            // value 7 on pin two select turns pin one into an input
            reference_select_pin_one_oe_n <= (st2_sel == 3'h7);
            reference_select_pin_one_out  <= status_src[0];
            reference_select <= (st2_sel == 3'h7) ? reference_select_pin_one_in : 1'b0;
        end
    end

endmodule : clock_distribution_divider_delay

// >>> clkdist_props.sv
/*
 * checker for the clock distribution block on the top module ports.
 * assumes pair 0 and misc setup change only through the register port.
 */
`timescale 1ns/1ps
module clkdist_props #(
    parameter int PAIRS = 7
) (
    // clock and reset
    input wire logic               mclk,
    input wire logic               nrst,
    // register port
    input wire logic [7:0]         addr,
    input wire logic [31:0]        wdata,
    input wire logic               wr,
    input wire logic               rd,
    input wire logic [31:0]        rdata,
    // pins
    input wire logic               sync_path,
    input wire logic               second_loop_oscillator_input,
    input wire logic [3:0]         status_src,
    input wire logic [2*PAIRS-1:0] clock_output,
    input wire logic               buffered_oscillator_output,
    input wire logic               lock_status_pin_one
);
    logic [31:0] cfg0;
    logic [10:0] misc;
    logic        misc_seen;
    logic [3:0]  src_q;
    logic        osc_q;
    logic        even_bad;
    // ----------------------------------------
    // shadow setup
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cfg0 <= 32'h0022_8004;
        end else if (wr && addr == 8'h00) begin
            cfg0 <= wdata;
        end
    end
    // misc reset value is not pinned down, so wait for a write
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            misc_seen <= 1'b0;
        end else if (wr && addr == 8'h48) begin
            misc_seen <= 1'b1;
        end
    end
    always_ff @(posedge mclk) begin
        if (wr && addr == 8'h48) begin
            misc <= wdata[10:0];
        end
    end
    always_ff @(posedge mclk) begin
        src_q <= status_src;
        osc_q <= second_loop_oscillator_input;
    end
    assign even_bad = cfg0[11] ? (cfg0[15:14] != 2'h1) : (cfg0[15:14] < 2'h2);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not zero outside answer cycle");
    a_unmapped_zero: assert property (rd && addr >= 8'h50 |=> rdata == 32'h0)
        else $error("unmapped read gave nonzero data");
    a_sync_hold: assert property (sync_path[*3] ##0 (!cfg0[29] && !cfg0[11])
        |-> clock_output[1:0] == 2'b00)
        else $error("pair 0 not held while sync high");
    a_dcc_off_pulse: assert property ($rose(clock_output[1]) && !cfg0[10] && cfg0[9:0] > 10'h1 && cfg0[13:11] == 3'h0 |=> !clock_output[1])
        else $error("odd output high longer than one cycle");
    a_even_fmt_gate: assert property (even_bad && $stable(cfg0) |=> clock_output[0] == 1'b0)
        else $error("even output runs with illegal format");
    a_bypass_pass: assert property (cfg0[11] && !even_bad && $stable(cfg0) |=> clock_output[0] == 1'b1)
        else $error("bypass output not passing path clock");
    a_osc_follow: assert property (misc_seen && $stable(misc) && misc[1:0] == 2'h0 && $past(nrst)
        |-> buffered_oscillator_output == osc_q)
        else $error("oscillator output not following its input");
    a_lock1_sel: assert property (misc_seen && $stable(misc) && !misc[7] && $past(nrst)
        |-> lock_status_pin_one == src_q[misc[6:5]])
        else $error("status pin one not showing selected source");
endmodule : clkdist_props
bind clock_distribution_divider_delay clkdist_props #(.PAIRS(PAIRS)) clkdist_props_inst (
    .mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .sync_path(sync_path), .second_loop_oscillator_input(second_loop_oscillator_input),
    .status_src(status_src), .clock_output(clock_output),
    .buffered_oscillator_output(buffered_oscillator_output),
    .lock_status_pin_one(lock_status_pin_one)
);

// >>> clock_sink.sv
/*
 * receiving converters: count rising edges on every clock output.
 * assumes clear is driven by the bench off the clock edge.
 */
`timescale 1ns/1ps
module clock_sink (
    // clock and control
    input wire logic        mclk,
    input wire logic        clear,
    // received clocks and counts
    input wire logic [13:0] clk_in,
    output int              edges [14]
);
    logic [13:0] prev;
    always_ff @(posedge mclk) begin
        prev <= clk_in;
        for (int i = 0; i < 14; i++) begin
            edges[i] <= clear ? 0 : edges[i] + int'(clk_in[i] && !prev[i]);
        end
    end
endmodule : clock_sink

// >>> clock_distribution_divider_delay_test.sv
/*
 * self-checking bench for the clock distribution block.
 * assumes the design header and package are compiled first.
 */
`timescale 1ns/1ps
module clock_distribution_divider_delay_test;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        sync_path = 1'b0;
    logic        osc_in = 1'b0;
    logic [3:0]  status_src = 4'h0;
    logic        clear = 1'b0;
    logic        pin_out, pin_oe_n, pin_in, osc_out, lock_one, pd_ref;
    logic [31:0] rdata, d;
    logic [13:0] clock_output;
    int          edges [14];
    int          mismatches = 0;
    int          compares = 0;
    int          cycles = 0;
    int          n;
    always #2 mclk = ~mclk;
    // pull-up on the shared select pin when nobody drives it
    assign pin_in = pin_oe_n ? 1'b1 : pin_out;
    clock_distribution_divider_delay clock_distribution_divider_delay_inst (
        .mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .sync_path(sync_path), .second_loop_oscillator_input(osc_in),
        .first_loop_reference_input(1'b0), .external_feedback_input(1'b0),
        .status_src(status_src), .clock_output(clock_output), .clock_output_half(),
        .buffered_oscillator_output(osc_out), .pd_reference(pd_ref), .pd_feedback(),
        .lock_status_pin_one(lock_one), .lock_status_pin_two(),
        .reference_select_pin_one_in(pin_in), .reference_select_pin_one_out(pin_out),
        .reference_select_pin_one_oe_n(pin_oe_n), .reference_select());
    clock_sink clock_sink_inst (.mclk(mclk), .clear(clear), .clk_in(clock_output), .edges(edges));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg
    task automatic window(input int c);
        repeat (20) @(posedge mclk);
        clear <= 1'b1;
        @(posedge mclk);
        clear <= 1'b0;
        repeat (c) @(posedge mclk);
        #1;
    endtask : window
    task automatic wait_rise(input int i, output int k);
        k = 0;
        do begin
            @(posedge mclk);
            #1 k++;
        end while (clock_output[i] !== 1'b1 && k < 200);
    endtask : wait_rise
    function automatic logic [31:0] cfgw(input logic [9:0] dv, input logic [9:0] dl, input logic sd);
        return {2'b00, sd, 1'b0, dl, 4'hA, 4'h0, dv};
    endfunction : cfgw
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd_reg(8'h00, d); chk("pair0 cfg", cfgw(10'h004, 10'h008, 1'b0), d);
        rd_reg(8'h40, d); chk("sysref cfg", 32'h0001_0080, d);
        rd_reg(8'h20, d); chk("local sdly", 32'h0000_0001, d);
        rd_reg(8'h50, d); chk("unmapped", 32'h0, d);
        $display("reset test done");
    endtask : t_reset
    task automatic t_divide;
        int dv [3] = '{2, 5, 9};
        foreach (dv[i]) begin
            wr_reg(8'h00, cfgw(10'(dv[i]), 10'h008, 1'b0));
            window(90);
            chk("odd edges", 32'(90 / dv[i]), 32'(edges[1]));
            chk("even edges", 32'(90 / dv[i]), 32'(edges[0]));
        end
        $display("divide test done");
    endtask : t_divide
    task automatic t_format;
        wr_reg(8'h00, cfgw(10'h005, 10'h008, 1'b0) ^ 32'h0000_C000);
        window(30);
        rd_reg(8'h4C, d); chk("cml divided flag", 32'h1, d & 32'h1);
        chk("cml divided edges", 32'h0, 32'(edges[0]));
        wr_reg(8'h00, cfgw(10'h005, 10'h008, 1'b0) ^ 32'h0000_C800);
        rd_reg(8'h4C, d); chk("cml bypass flag", 32'h0, d & 32'h1);
        chk("bypass level", 32'h1, 32'(clock_output[0]));
        wr_reg(8'h00, cfgw(10'h005, 10'h008, 1'b0) ^ 32'h0003_0800);
        window(30);
        rd_reg(8'h4C, d); chk("lvds bypass flag", 32'h1, d & 32'h1);
        chk("odd cml edges", 32'h6, 32'(edges[1]));
        $display("format test done");
    endtask : t_format
    task automatic t_sync;
        // divide five needs no four step
        wr_reg(8'h00, cfgw(10'h005, 10'h008, 1'b0));
        wr_reg(8'h04, cfgw(10'h005, 10'h008, 1'b1));
        wr_reg(8'h08, cfgw(10'h005, 10'h008, 1'b0));
        sync_path <= 1'b1;
        window(30);
        chk("held edges", 32'h0, 32'(edges[1]));
        chk("exempt edges", 32'h6, 32'(edges[3]));
        rd_reg(8'h4C, d); chk("sync flag", 32'h80, d & 32'h80);
        sync_path <= 1'b0;
        wait_rise(1, n); chk("aligned", 32'h1, 32'(clock_output[5]));
        wr_reg(8'h08, cfgw(10'h005, 10'h00C, 1'b0));
        wait_rise(1, n); chk("delay waits sync", 32'h1, 32'(clock_output[5]));
        sync_path <= 1'b1;
        repeat (3) @(posedge mclk);
        sync_path <= 1'b0;
        wait_rise(1, n);
        wait_rise(5, n); chk("delay offset", 32'h4, 32'(n));
        $display("sync test done");
    endtask : t_sync
    task automatic t_dynamic;
        wr_reg(8'h00, cfgw(10'h005, 10'h008, 1'b1));
        // global delay is half divide plus one
        wr_reg(8'h40, 32'h0001_2010);
        wr_reg(8'h44, 32'h0000_0103);
        rd_reg(8'h44, d); chk("dyn start", 32'h103, d);
        repeat (100) @(posedge mclk);
        rd_reg(8'h44, d); chk("dyn done", 32'h100, d);
        $display("dynamic test done");
    endtask : t_dynamic
    task automatic t_misc;
        wr_reg(8'h48, 32'h0000_0020);
        rd_reg(8'h48, d); chk("misc", 32'h20, d);
        for (int v = 0; v < 2; v++) begin
            osc_in <= v[0];
            status_src <= {2'b00, v[0], 1'b0};
            repeat (3) @(posedge mclk);
            #1 chk("osc out", 32'(v), 32'(osc_out));
            chk("status one", 32'(v), 32'(lock_one));
            chk("pd reference", 32'(v), 32'(pd_ref));
        end
        $display("misc test done");
    endtask : t_misc
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    // a hang costs at most this many cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report;
        end
    end
    initial begin
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        t_reset;
        t_divide;
        t_format;
        t_sync;
        t_dynamic;
        t_misc;
        final_report;
    end
endmodule : clock_distribution_divider_delay_test
